// file: core/drive_alarm_status_regs.sv
// fault and status flag words of the stepper drive, read over the register port
`timescale 1ns/1ns
`default_nettype none

module drive_alarm_status_regs
   import drive_flags_pkg::*;
#(
   parameter int unsigned READY_DELAY = drive_flags_pkg::READY_CYCLES
) (
   // clock and reset
   input  wire logic                         clk,
   input  wire logic                         rst,
   // fault conditions from sensing logic
   input  wire logic                         encoder_fault,
   input  wire logic                         tracking_error,
   input  wire logic                         phase_loss_alarm,
   input  wire logic                         param_check_error,
   input  wire logic                         heat_alarm,
   input  wire logic                         supply_low_alarm,
   input  wire logic                         supply_high_alarm,
   input  wire logic                         current_alarm,
   input  wire logic                         internal_rail_fault,
   // drive state conditions
   input  wire logic                         torque_reached,
   input  wire logic                         supply_present,
   input  wire logic                         neg_limit_hit,
   input  wire logic                         pos_limit_hit,
   input  wire logic                         brake_released,
   input  wire logic                         speed_reached,
   input  wire logic                         homing_done,
   input  wire logic                         in_motion,
   input  wire logic                         position_settled,
   // mode qualifiers
   input  wire logic                         internal_pulse_mode,
   input  wire logic                         closed_loop_mode,
   // enable control, one-cycle pulses from the command decoder
   input  wire logic                         enable_req,
   input  wire logic                         disable_req,
   // motion command gate
   input  wire logic                         motion_cmd,
   input  wire logic                         stop_cmd,
   output logic                              motion_cmd_accept,
   output logic                              stop_cmd_accept,
   // register read port
   input  wire logic                         rd_en,
   input  wire logic [drive_flags_pkg::ADDR_W-1:0] rd_addr,
   output logic [drive_flags_pkg::WORD_W-1:0]      rd_data,
   output logic                              rd_valid,
   output logic                              rd_error,
   // flag outputs
   output logic                              drive_active,
   output logic                              drive_ready,
   output logic                              alarm_present
);
   import drive_flags_pkg::*;

   // nine fault pins, nine state pins and the two mode qualifiers
   localparam int unsigned IN_BITS = FAULT_BITS + STATUS_BITS - 3 + 2;

   flag_sync_if #(.WIDTH(IN_BITS)) cond ();

   logic [FAULT_BITS-1:0]  fault_flags;
   logic [IN_BITS-1:0]     in_sync;
   logic                   ready_flag;
   logic [READY_CNT_W-1:0] ready_cnt;
   logic [WORD_W-1:0]      fault_word;
   logic [WORD_W-1:0]      status_word;
   logic                   speed_bit;
   logic                   settled_bit;

   // all condition pins arrive from outside the clock domain
   assign cond.raw = {internal_pulse_mode, closed_loop_mode, position_settled, in_motion,
                      homing_done, speed_reached, brake_released, pos_limit_hit,
                      neg_limit_hit, supply_present, torque_reached, encoder_fault,
                      tracking_error, phase_loss_alarm, param_check_error, heat_alarm,
                      supply_low_alarm, supply_high_alarm, current_alarm,
                      internal_rail_fault};

   flag_sync #(.WIDTH(IN_BITS)) u_sync (
      .clk  (clk),
      .rst  (rst),
      .bank (cond)
   );

   assign in_sync = cond.clean;

   // fault flags follow their conditions, live
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fault_flags <= FAULT_RESET[FAULT_BITS-1:0];
      end else begin
         fault_flags[F_ENCODER]  <= in_sync[F_ENCODER];
         fault_flags[F_TRACK]    <= in_sync[F_TRACK];
         fault_flags[F_PHASE]    <= in_sync[F_PHASE];
         fault_flags[F_PARAM]    <= in_sync[F_PARAM];
         fault_flags[F_HEAT]     <= in_sync[F_HEAT];
         fault_flags[F_SUP_LOW]  <= in_sync[F_SUP_LOW];
         fault_flags[F_SUP_HIGH] <= in_sync[F_SUP_HIGH];
         fault_flags[F_CURRENT]  <= in_sync[F_CURRENT];
         fault_flags[F_RAIL]     <= in_sync[F_RAIL];
      end
   end

   assign alarm_present = |fault_flags;

   // enable state; powers up enabled
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         drive_active <= ACTIVE_RESET;
      end else if (disable_req) begin
         drive_active <= 1'b0;
      end else if (enable_req) begin
         drive_active <= 1'b1;
      end
   end

   // ready only after the enable has held for the full delay
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ready_cnt  <= '0;
         ready_flag <= 1'b0;
      end else if (!drive_active) begin
         ready_cnt  <= '0;
         ready_flag <= 1'b0;
      end else if (ready_cnt >= READY_CNT_W'(READY_DELAY - 1)) begin
         ready_flag <= 1'b1;
      end else begin
         ready_cnt <= ready_cnt + 1'b1;
      end
   end

   assign drive_ready = ready_flag;

   // mode-qualified status bits
   assign speed_bit   = in_sync[IN_BITS-1] & in_sync[FAULT_BITS+5];
   assign settled_bit = in_sync[IN_BITS-2] & in_sync[FAULT_BITS+8];

   // while running only a stop is taken
   assign motion_cmd_accept = motion_cmd & ~in_sync[FAULT_BITS+7];
   assign stop_cmd_accept   = stop_cmd;

   always_comb begin
      fault_word                     = '0;
      fault_word[FAULT_BITS-1:0]     = fault_flags;
      status_word                    = '0;
      status_word[S_TORQUE]          = in_sync[FAULT_BITS];
      status_word[S_SUPPLY]          = in_sync[FAULT_BITS+1];
      status_word[S_NEG_LIM]         = in_sync[FAULT_BITS+2];
      status_word[S_POS_LIM]         = in_sync[FAULT_BITS+3];
      status_word[S_BRAKE]           = in_sync[FAULT_BITS+4];
      status_word[S_SPEED]           = speed_bit;
      status_word[S_READY]           = ready_flag;
      status_word[S_HOMED]           = in_sync[FAULT_BITS+6];
      status_word[S_MOTION]          = in_sync[FAULT_BITS+7];
      status_word[S_SETTLED]         = settled_bit;
      status_word[S_ALARM]           = alarm_present;
      status_word[S_ACTIVE]          = drive_active;
   end

   // registered read answer, one cycle after the request
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_data  <= '0;
         rd_valid <= 1'b0;
         rd_error <= 1'b0;
      end else begin
         rd_valid <= rd_en;
         rd_error <= 1'b0;
         rd_data  <= '0;
         if (rd_en) begin
            case (rd_addr)
               ADDR_FAULT:  rd_data <= fault_word;
               ADDR_STATUS: rd_data <= status_word;
               default:     rd_error <= 1'b1;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// file: core/drive_flags_pkg.sv
// shared offsets, field positions, reset values and timing for the drive flag words
package drive_flags_pkg;
   localparam int unsigned CLK_HZ        = 100_000_000;
   localparam int unsigned WORD_W        = 16;
   localparam int unsigned ADDR_W        = 16;
   // register addresses
   localparam logic [15:0] ADDR_FAULT    = 16'h0000;
   localparam logic [15:0] ADDR_STATUS   = 16'h0001;
   // fault word fields
   localparam int unsigned F_RAIL        = 0;
   localparam int unsigned F_CURRENT     = 1;
   localparam int unsigned F_SUP_HIGH    = 2;
   localparam int unsigned F_SUP_LOW     = 3;
   localparam int unsigned F_HEAT        = 4;
   localparam int unsigned F_PARAM       = 5;
   localparam int unsigned F_PHASE       = 6;
   localparam int unsigned F_TRACK       = 7;
   localparam int unsigned F_ENCODER     = 8;
   localparam int unsigned FAULT_BITS    = 9;
   // status word fields
   localparam int unsigned S_ACTIVE      = 0;
   localparam int unsigned S_ALARM       = 1;
   localparam int unsigned S_SETTLED     = 2;
   localparam int unsigned S_MOTION      = 3;
   localparam int unsigned S_HOMED       = 4;
   localparam int unsigned S_READY       = 5;
   localparam int unsigned S_SPEED       = 6;
   localparam int unsigned S_BRAKE       = 7;
   localparam int unsigned S_POS_LIM     = 8;
   localparam int unsigned S_NEG_LIM     = 9;
   localparam int unsigned S_SUPPLY      = 10;
   localparam int unsigned S_TORQUE      = 11;
   localparam int unsigned STATUS_BITS   = 12;
   // reset values
   localparam logic [15:0] FAULT_RESET   = 16'h0000;
   localparam logic [15:0] STATUS_RESET  = 16'h0001;
   localparam logic        ACTIVE_RESET  = 1'b1;
   // ready delay after enabling
   localparam int unsigned READY_DELAY_MS = 100;
   localparam int unsigned READY_CYCLES   = READY_DELAY_MS * (CLK_HZ / 1000);
   localparam int unsigned READY_CNT_W    = 24;
endpackage

// file: core/flag_sync_if.sv
// carrier between the flag word module and its input synchroniser
`timescale 1ns/1ns
`default_nettype none
interface flag_sync_if #(parameter int WIDTH = 8);
   logic [WIDTH-1:0] raw;
   logic [WIDTH-1:0] clean;
   modport sync (input raw, output clean);
   modport user (output raw, input clean);
endinterface
`default_nettype wire

// file: core/flag_sync.sv
// two-flop synchroniser for a bank of asynchronous condition inputs
`timescale 1ns/1ns
`default_nettype none
module flag_sync #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // condition bank
   flag_sync_if.sync bank
);
   logic [WIDTH-1:0] stage_a;
   logic [WIDTH-1:0] stage_b;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stage_a <= '0;
         stage_b <= '0;
      end else begin
         stage_a <= bank.raw;
         stage_b <= stage_a;
      end
   end

   assign bank.clean = stage_b;
endmodule
`default_nettype wire

// file: testbench/flag_master.sv
// register port master that reads one word at a time
`timescale 1ns/1ns
`default_nettype none
module flag_master (
   input  wire logic        clk,
   input  wire logic        rd_valid,
   input  wire logic        rd_error,
   input  wire logic [15:0] rd_data,
   output logic             rd_en,
   output logic [15:0]      rd_addr
);
   initial begin
      rd_en = 1'b0;
      rd_addr = 16'h0;
   end
   task automatic read(input logic [15:0] a, output logic [15:0] d, output logic e);
      @(posedge clk);
      rd_en <= 1'b1;
      rd_addr <= a;
      @(posedge clk);
      rd_en <= 1'b0;
      rd_addr <= ~a;
      #1;
      for (int n = 0; n < 4 && rd_valid !== 1'b1; n++) @(posedge clk) #1;
      d = rd_valid ? rd_data : 16'hXXXX;
      e = rd_error;
   endtask
endmodule
`default_nettype wire

// file: testbench/drive_flags_checker.sv
// port assertions for the drive flag words
`timescale 1ns/1ns
`default_nettype none
module drive_flags_checker #(
   parameter int unsigned READY_DELAY = 20
) (
   input wire logic        clk, rst, rd_en, rd_valid, rd_error,
   input wire logic [15:0] rd_addr, rd_data,
   input wire logic        enable_req, disable_req, drive_active, drive_ready,
   input wire logic        alarm_present, motion_cmd, motion_cmd_accept,
   input wire logic        stop_cmd, stop_cmd_accept
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic [23:0] cnt;
   // cycles spent enabled, for the ready delay
   always_ff @(posedge clk or posedge rst)
      if (rst) cnt <= '0;
      else cnt <= drive_active ? cnt + 24'd1 : '0;
   read_answer_a: assert property (rd_en |=> rd_valid) else $error("no answer");
   read_idle_a: assert property (!rd_en |=> !rd_valid && rd_data == 16'h0)
      else $error("spurious read data");
   unmapped_err_a: assert property (
      rd_en && rd_addr > 16'h1 |=> rd_error && rd_data == 16'h0)
      else $error("unmapped read");
   fault_top_a: assert property (
      rd_en && rd_addr == 16'h0 |=> rd_data[15:9] == 7'h0)
      else $error("upper fault bits");
   alarm_sum_a: assert property (
      rd_en && rd_addr == 16'h0 |=> (|rd_data[8:0]) == $past(alarm_present))
      else $error("summary alarm");
   active_bit_a: assert property (
      rd_en && rd_addr == 16'h1 |=> rd_data[0] == $past(drive_active))
      else $error("enabled bit");
   enable_act_a: assert property (enable_req && !disable_req |=> drive_active)
      else $error("enable lost");
   ready_off_a: assert property (!drive_active |=> !drive_ready)
      else $error("ready early");
   ready_wait_a: assert property ($rose(drive_ready) |-> cnt >= READY_DELAY - 1)
      else $error("ready delay short");
   motion_gate_a: assert property (motion_cmd_accept |-> motion_cmd)
      else $error("gate");
   stop_take_a: assert property (stop_cmd |-> stop_cmd_accept)
      else $error("stop refused");
   cover property (rd_en && rd_addr > 16'h1);
   cover property ($rose(drive_ready));
   cover property (motion_cmd && !motion_cmd_accept);
endmodule
bind drive_alarm_status_regs drive_flags_checker #(.READY_DELAY(READY_DELAY)) chk_i (
   .clk(clk), .rst(rst), .rd_en(rd_en), .rd_valid(rd_valid), .rd_error(rd_error),
   .rd_addr(rd_addr), .rd_data(rd_data), .enable_req(enable_req), .disable_req(disable_req),
   .drive_active(drive_active), .drive_ready(drive_ready), .alarm_present(alarm_present),
   .motion_cmd(motion_cmd), .motion_cmd_accept(motion_cmd_accept), .stop_cmd(stop_cmd),
   .stop_cmd_accept(stop_cmd_accept));
`default_nettype wire

// file: testbench/test_drive_alarm_status_regs.sv
// self-checking bench for the drive flag words
`timescale 1ns/1ns
`default_nettype none
module test_drive_alarm_status_regs;
   import drive_flags_pkg::*;
   localparam int RD = 20;
   logic clk, rst, pm, cl, en_req, dis_req, mcmd, scmd, rd_en, rd_valid, rd_error, mac, sac, e;
   logic da, dr, ap;
   logic [8:0] flt;
   logic [11:0] st;
   logic [15:0] rd_addr, rd_data, d;
   int fails, n_compared, cyc;
   drive_alarm_status_regs #(.READY_DELAY(RD)) uut (.clk(clk), .rst(rst),
      .encoder_fault(flt[F_ENCODER]), .tracking_error(flt[F_TRACK]),
      .phase_loss_alarm(flt[F_PHASE]), .param_check_error(flt[F_PARAM]),
      .heat_alarm(flt[F_HEAT]), .supply_low_alarm(flt[F_SUP_LOW]),
      .supply_high_alarm(flt[F_SUP_HIGH]), .current_alarm(flt[F_CURRENT]),
      .internal_rail_fault(flt[F_RAIL]), .torque_reached(st[S_TORQUE]),
      .supply_present(st[S_SUPPLY]), .neg_limit_hit(st[S_NEG_LIM]), .pos_limit_hit(st[S_POS_LIM]),
      .brake_released(st[S_BRAKE]), .speed_reached(st[S_SPEED]), .homing_done(st[S_HOMED]),
      .in_motion(st[S_MOTION]), .position_settled(st[S_SETTLED]), .internal_pulse_mode(pm),
      .closed_loop_mode(cl), .enable_req(en_req), .disable_req(dis_req), .motion_cmd(mcmd),
      .stop_cmd(scmd), .motion_cmd_accept(mac), .stop_cmd_accept(sac), .rd_en(rd_en),
      .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid), .rd_error(rd_error),
      .drive_active(da), .drive_ready(dr), .alarm_present(ap));
   flag_master m (.clk(clk), .rd_valid(rd_valid), .rd_error(rd_error), .rd_data(rd_data),
      .rd_en(rd_en), .rd_addr(rd_addr));
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rdchk(input logic [15:0] a, input logic [15:0] x, input logic xe);
      m.read(a, d, e);
      chk(d, x);
      chk(16'(e), 16'(xe));
   endtask
   // expected status word from the bench's own view of the inputs
   function automatic logic [15:0] xs(input logic a, input logic r);
      logic [15:0] v;
      v = {4'h0, st};
      v[S_SPEED] = st[S_SPEED] & pm;
      v[S_SETTLED] = st[S_SETTLED] & cl;
      v[S_READY] = r;
      v[S_ALARM] = |flt;
      v[S_ACTIVE] = a;
      return v;
   endfunction
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         fails++;
         conclude();
      end
   end
   initial begin
      rst = 1'b1;
      {flt, st, pm, cl, en_req, dis_req, mcmd, scmd} = '0;
      void'($urandom(32'hFD646FCE));
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rdchk(ADDR_FAULT, 16'h0000, 1'b0);
      rdchk(ADDR_STATUS, xs(1'b1, 1'b0), 1'b0);
      chk(16'({da, dr, ap}), 16'h0004);
      $display("reset test done");
      repeat (RD) @(posedge clk);
      for (int i = 0; i < 40; i++) begin
         @(posedge clk);
         flt <= (i < 9) ? 9'(1 << i) : 9'($urandom);
         st <= 12'($urandom);
         pm <= 1'($urandom);
         cl <= 1'($urandom);
         repeat (4) @(posedge clk);
         rdchk(ADDR_FAULT, {7'h0, flt}, 1'b0);
         rdchk(ADDR_STATUS, xs(1'b1, 1'b1), 1'b0);
         chk(16'({da, dr, ap}), 16'({2'b11, |flt}));
      end
      $display("flag test done");
      rdchk(16'h0002, 16'h0000, 1'b1);
      rdchk(16'hFFFF, 16'h0000, 1'b1);
      @(posedge clk);
      st <= 12'h008;
      mcmd <= 1'b1;
      scmd <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk(16'({mac, sac}), 16'h0001);
      @(posedge clk);
      st <= 12'h000;
      repeat (3) @(posedge clk);
      #1 chk(16'({mac, sac}), 16'h0003);
      @(posedge clk);
      {mcmd, scmd, en_req, dis_req} <= 4'hF;
      @(posedge clk);
      {mcmd, scmd, en_req, dis_req} <= 4'h0;
      rdchk(ADDR_STATUS, xs(1'b0, 1'b0), 1'b0);
      chk(16'({da, dr}), 16'h0000);
      @(posedge clk);
      en_req <= 1'b1;
      @(posedge clk);
      en_req <= 1'b0;
      rdchk(ADDR_STATUS, xs(1'b1, 1'b0), 1'b0);
      chk(16'({da, dr}), 16'h0002);
      repeat (RD + 2) @(posedge clk);
      rdchk(ADDR_STATUS, xs(1'b1, 1'b1), 1'b0);
      chk(16'({da, dr}), 16'h0003);
      $display("command and enable test done");
      conclude();
   end
endmodule
`default_nettype wire
